// ===== conv_ctrl_top.sv
/*
  Register side for four converters: activity status, per-converter setup
  registers, reset requests, and four serial setup engines behind them.
  Assumes a classic Wishbone master, 32-bit data, byte addresses, and
  acquisition logic elsewhere that reports sampling and result transfer.
*/
// Design decision made here: the Wishbone interface to the registers.
// Overview of operation
// - Four read-only activity flags, bits 3:0.
// - Flag high during sampling, transfer, reset, setup.
// - Setup write queues serial transfer to converter.
// - Setup write sets flag until transfer done.
// - Reset request followed by automatic reconfiguration.
// - One topology bit per converter, all channels.
// - Setup registers at 0x010, 0x054, 0x098, 0x0DC.
// - Bit 27 topology, resets to one.
// - Bits 26:24 channel count, bit 26 ignored differential.
// - Channels start at zero, ascending, four maximum differential.
// - Three-bit range code per channel, reset 111.
// - Reset request pulses pin, reconfigures, self-clears.
`timescale 1ns/1ps
module conv_ctrl_top
  import conv_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [conv_ctrl_pkg::ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [conv_ctrl_pkg::DAT_W-1:0] i_wb_dat,
  output logic [conv_ctrl_pkg::DAT_W-1:0] o_wb_dat,
  output logic o_wb_ack,
  // Acquisition activity per converter
  input wire logic [conv_ctrl_pkg::NUM_CONV-1:0] i_acq_active,
  // Decoded setup for the acquisition logic
  output logic [conv_ctrl_pkg::NUM_CONV-1:0] o_differential_topology,
  output logic [conv_ctrl_pkg::NUM_CONV-1:0][conv_ctrl_pkg::CHAN_MAX-1:0] o_chan_enable,
  // Converter serial setup pins
  output logic [conv_ctrl_pkg::NUM_CONV-1:0] o_cfg_sclk,
  output logic [conv_ctrl_pkg::NUM_CONV-1:0] o_cfg_cs_n,
  output logic [conv_ctrl_pkg::NUM_CONV-1:0] o_cfg_sdo,
  output logic [conv_ctrl_pkg::NUM_CONV-1:0] o_conv_reset
);
  import conv_ctrl_pkg::*;

  localparam int DIV_W = $clog2(SCLK_DIV + 1);

  // Index of setup register hit by an address, or NUM_CONV for none
  function automatic logic [2:0] setup_index(input logic [ADR_W-1:0] adr);
    logic [2:0] idx;
    idx = 3'(NUM_CONV);
    case (adr)
      OFS_SETUP0: idx = 3'h0;
      OFS_SETUP1: idx = 3'h1;
      OFS_SETUP2: idx = 3'h2;
      OFS_SETUP3: idx = 3'h3;
      default: idx = 3'(NUM_CONV);
    endcase
    return idx;
  endfunction : setup_index

  // Byte-lane merge for partial writes
  function automatic logic [DAT_W-1:0] merge_sel(input logic [DAT_W-1:0] old_v,
                                                  input logic [DAT_W-1:0] new_v,
                                                  input logic [3:0] sel);
    logic [DAT_W-1:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_sel

  // Channel set from count field; bit 26 dropped in differential topology
  function automatic logic [CHAN_MAX-1:0] chan_mask(input logic [DAT_W-1:0] setup);
    logic [3:0] cnt;
    logic [CHAN_MAX:0] ones;
    cnt = 4'h0;
    ones = '0;
    if (setup[TOPO_BIT]) begin
      cnt = {1'b0, setup[CNT_MSB:CNT_LSB]};
    end else begin
      cnt = {2'b00, setup[CNT_MSB-1:CNT_LSB]};
    end
    ones = (9'h001 << (cnt + 4'h1)) - 9'h001;
    return ones[CHAN_MAX-1:0];
  endfunction : chan_mask

  // Reset release through two flip-flops
  logic rst_meta_q;
  logic rst_n;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // Bus decode
  logic ack_q;
  logic req;
  logic wr_take;
  logic [2:0] wr_idx;
  assign req = i_wb_cyc && i_wb_stb;
  // Write lands on the edge at which the master sees ack
  assign wr_take = req && i_wb_we && ack_q;
  assign wr_idx = setup_index(i_wb_adr);
  assign o_wb_ack = ack_q;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  // Setup registers; reserved bits 31:28 are not stored
  logic [NUM_CONV-1:0][DAT_W-1:0] setup_q;
  logic [NUM_CONV-1:0] cfg_wr;
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CONV; i++) begin
        setup_q[i] <= SETUP_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_CONV; i++) begin
        if (cfg_wr[i]) begin
          setup_q[i] <= merge_sel(setup_q[i], i_wb_dat, i_wb_sel) & SETUP_MASK;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CONV; i++) begin
      cfg_wr[i] = wr_take && (wr_idx == 3'(i));
    end
  end

  // Reset requests: software sets, engine clears at end of reconfiguration
  logic [NUM_CONV-1:0] rst_req_q;
  logic [NUM_CONV-1:0] rst_done;
  logic rst_set_wr;
  assign rst_set_wr = wr_take && (i_wb_adr == OFS_CTRL) && i_wb_sel[RST_REQ_LSB / 8];
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_req_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CONV; i++) begin
        // A new request beats the clear of the finished one
        if (rst_set_wr && i_wb_dat[RST_REQ_LSB + i]) begin
          rst_req_q[i] <= 1'b1;
        end else if (rst_done[i]) begin
          rst_req_q[i] <= 1'b0;
        end
      end
    end
  end

  // Link bit-rate divider
  logic [DIV_W-1:0] div_q;
  logic tick;
  assign tick = (div_q == '0);
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= DIV_W'(SCLK_DIV - 1);
    end else if (tick) begin
      div_q <= DIV_W'(SCLK_DIV - 1);
    end else begin
      div_q <= div_q - 1'b1;
    end
  end

  // Engines, one per converter
  logic [NUM_CONV-1:0] eng_busy;
  for (genvar g = 0; g < NUM_CONV; g++) begin : g_conv
    conv_cfg_if link ();
    assign link.setup = setup_q[g];
    assign link.cfg_write = cfg_wr[g];
    assign link.rst_req = rst_req_q[g];
    assign link.tick = tick;
    assign eng_busy[g] = link.busy;
    assign rst_done[g] = link.rst_done;

    conv_cfg_engine u_engine (
      .i_clk(i_ref_clk),
      .i_rst_n(rst_n),
      .link(link.engine),
      .o_sclk(o_cfg_sclk[g]),
      .o_cs_n(o_cfg_cs_n[g]),
      .o_sdo(o_cfg_sdo[g]),
      .o_conv_reset(o_conv_reset[g])
    );
  end

  // Activity flags
  logic [NUM_CONV-1:0] busy_q;
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= '0;
    end else begin
      busy_q <= i_acq_active | eng_busy | rst_req_q;
    end
  end

  // Decoded setup, registered for the acquisition side
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_differential_topology <= '0;
      o_chan_enable <= '0;
    end else begin
      for (int i = 0; i < NUM_CONV; i++) begin
        o_differential_topology[i] <= !setup_q[i][TOPO_BIT];
        o_chan_enable[i] <= chan_mask(setup_q[i]);
      end
    end
  end

  // Read data; unmapped addresses read zero and writes to them are dropped
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_wb_dat <= '0;
    end else if (req && !ack_q) begin
      if (i_wb_adr == OFS_STATUS) begin
        o_wb_dat <= DAT_W'(busy_q);
      end else if (i_wb_adr == OFS_CTRL) begin
        o_wb_dat <= DAT_W'(rst_req_q) << RST_REQ_LSB;
      end else if (wr_idx != 3'(NUM_CONV)) begin
        o_wb_dat <= setup_q[wr_idx[1:0]];
      end else begin
        o_wb_dat <= '0;
      end
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!rst_n);

  a_ack_single_pulse: assert property (
    o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  a_ack_answers_req: assert property (
    (req && !o_wb_ack) |=> o_wb_ack)
    else $error("request not acknowledged in next cycle");
  a_status_upper_zero: assert property (
    (req && !i_wb_we && !o_wb_ack && i_wb_adr == OFS_STATUS) |=> o_wb_dat[DAT_W-1:4] == '0)
    else $error("status reserved bits not zero");
  a_status_reads_busy: assert property (
    (req && !i_wb_we && !o_wb_ack && i_wb_adr == OFS_STATUS) |=> o_wb_dat[3:0] == $past(busy_q))
    else $error("status read does not show activity flags");
  a_busy_on_write: assert property (
    cfg_wr[0] |=> ##1 busy_q[0])
    else $error("activity flag not set after setup write");
  a_busy_acq_active: assert property (
    i_acq_active[2] |=> busy_q[2])
    else $error("activity flag low during acquisition");
  a_setup_stored: assert property (
    (cfg_wr[2] && i_wb_sel == 4'hF) |=> setup_q[2] == ($past(i_wb_dat) & SETUP_MASK))
    else $error("setup write not stored");
  a_rst_busy_cover: assert property (
    rst_req_q[1] |=> busy_q[1])
    else $error("activity flag low during reset cycle");
  a_rst_req_clears: assert property (
    (rst_done[1] && !rst_set_wr) |=> !rst_req_q[1])
    else $error("reset request not cleared at end");
  a_diff_chan_limit: assert property (
    !setup_q[1][TOPO_BIT] |=> o_chan_enable[1][CHAN_MAX-1:4] == '0 && o_chan_enable[1][0])
    else $error("differential channel set out of range");
  a_count_bit_ignored: assert property (
    (!setup_q[0][TOPO_BIT] && setup_q[0][CNT_MSB-1:CNT_LSB] == 2'b11) |=> o_chan_enable[0] == 8'h0F)
    else $error("differential count decoded wrong");
  a_busy_from_sources: assert property (
    (i_acq_active == '0 && eng_busy == '0 && rst_req_q == '0) |=> busy_q == '0)
    else $error("activity flag set with no source");
  a_busy_engine: assert property (
    eng_busy[2] |=> busy_q[2])
    else $error("activity flag low while engine busy");
  a_busy_during_frame: assert property (
    !o_cfg_cs_n[3] |-> busy_q[3])
    else $error("activity flag low during setup frame");
  a_ctrl_reads_req: assert property (
    (req && !i_wb_we && !o_wb_ack && i_wb_adr == OFS_CTRL) |=>
    o_wb_dat == (DAT_W'($past(rst_req_q)) << RST_REQ_LSB))
    else $error("control read does not show reset requests");
  a_setup_readback: assert property (
    (req && !i_wb_we && !o_wb_ack && i_wb_adr == OFS_SETUP3) |=>
    o_wb_dat == $past(setup_q[3]))
    else $error("setup read does not show register");
  a_unmapped_zero: assert property (
    (req && !i_wb_we && !o_wb_ack && wr_idx == 3'(NUM_CONV) && i_wb_adr != OFS_STATUS &&
    i_wb_adr != OFS_CTRL) |=> o_wb_dat == '0)
    else $error("unmapped read not zero");
  a_status_write_ignored: assert property (
    (wr_take && i_wb_adr == OFS_STATUS) |=> setup_q == $past(setup_q))
    else $error("status write changed a setup register");
  a_rst_req_sets: assert property (
    (rst_set_wr && i_wb_dat[RST_REQ_LSB + 1]) |=> rst_req_q[1])
    else $error("reset request not recorded");
  a_rst_pulse_requested: assert property (
    $rose(o_conv_reset[1]) |-> $past(rst_req_q[1]))
    else $error("converter reset without request");
  a_topology_on_write: assert property (
    (cfg_wr[2] && i_wb_sel[3] && !i_wb_dat[TOPO_BIT]) |=> ##1 o_differential_topology[2])
    else $error("differential topology not applied");
  a_diff_upper_off: assert property (
    !setup_q[2][TOPO_BIT] |=> o_chan_enable[2][CHAN_MAX-1:4] == '0)
    else $error("differential channel above three enabled");
  a_sel_keeps_bytes: assert property (
    (cfg_wr[0] && !i_wb_sel[0]) |=> setup_q[0][7:0] == $past(setup_q[0][7:0]))
    else $error("unselected setup byte changed");
  a_write_lands_ack: assert property (
    (req && i_wb_we && !o_wb_ack && i_wb_adr == OFS_SETUP1 && i_wb_sel == 4'hF) |=>
    ##1 setup_q[1] == ($past(i_wb_dat, 2) & SETUP_MASK))
    else $error("setup write not stored on ack");
  a_ack_idle: assert property (
    !req |=> !o_wb_ack)
    else $error("ack without request");
  a_pins_idle: assert property (
    o_cfg_cs_n[0] |-> !o_cfg_sclk[0])
    else $error("setup clock runs while deselected");
  a_sdo_stable_high: assert property (
    (o_cfg_sclk[1] && !o_cfg_cs_n[1]) |-> $stable(o_cfg_sdo[1]))
    else $error("setup data moved while clock high");

  c_setup_write: cover property (cfg_wr[0] ##[1:400] !eng_busy[0]);
  c_reconfig_frame: cover property ($fell(o_conv_reset[1]) ##[1:20] !o_cfg_cs_n[1]);
  c_reset_cycle: cover property (rst_req_q[0] ##[1:600] !rst_req_q[0]);
  c_status_busy_read: cover property (req && !i_wb_we && o_wb_ack && o_wb_dat[0]);
  c_rewrite_in_flight: cover property (cfg_wr[1] && !o_cfg_cs_n[1]);
endmodule : conv_ctrl_top

// ===== conv_ctrl_pkg.sv
/*
  Shared constants for the converter setup and activity block: register map,
  field layout, reset values, link timing and engine states.
  Assumes a 100 MHz system clock and byte addresses on the register bus.
*/
package conv_ctrl_pkg;

  localparam int NUM_CONV = 4;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int CHAN_MAX = 8;

  // Register byte offsets
  localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADR_W-1:0] OFS_SETUP0 = 8'h10;
  localparam logic [ADR_W-1:0] OFS_SETUP1 = 8'h54;
  localparam logic [ADR_W-1:0] OFS_SETUP2 = 8'h98;
  localparam logic [ADR_W-1:0] OFS_SETUP3 = 8'hDC;

  // Setup register layout
  localparam logic [DAT_W-1:0] SETUP_RESET = 32'h0FFF_FFFF;
  localparam logic [DAT_W-1:0] SETUP_MASK = 32'h0FFF_FFFF;
  localparam int TOPO_BIT = 27;
  localparam int CNT_MSB = 26;
  localparam int CNT_LSB = 24;
  localparam int RANGE_W = 3;
  localparam logic [RANGE_W-1:0] RANGE_RESET = 3'h7;

  // Control register layout
  localparam int RST_REQ_LSB = 16;
  localparam int FLAG_LSB = 0;

  // Link timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_PULSE_NS = 60;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_NS = 50;
  localparam int SCLK_DIV = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CFG_BITS = 28;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RESET = 2'b01,
    ST_SHIFT = 2'b10,
    ST_GAP = 2'b11
  } eng_state_t;

endpackage : conv_ctrl_pkg

// ===== conv_cfg_if.sv
/*
  Carrier between the register side and one serial setup engine.
  Assumes both ends share the system clock.
*/
`timescale 1ns/1ps
interface conv_cfg_if;
  import conv_ctrl_pkg::*;
  logic [DAT_W-1:0] setup;
  logic cfg_write;
  logic rst_req;
  logic tick;
  logic busy;
  logic rst_done;

  modport ctrl (output setup, output cfg_write, output rst_req, output tick,
                input busy, input rst_done);
  modport engine (input setup, input cfg_write, input rst_req, input tick,
                  output busy, output rst_done);
endinterface : conv_cfg_if

// ===== conv_cfg_engine.sv
/*
  Serial setup engine for one converter: reset pulse, pending transfer
  and MSB-first shift of the setup word, clocked out at the divider tick.
  Assumes a synchronous active-low reset copy and a one-cycle tick.
*/
`timescale 1ns/1ps
module conv_cfg_engine
  import conv_ctrl_pkg::*;
(
  // System
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register side
  conv_cfg_if.engine link,
  // Converter pins
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdo,
  output logic o_conv_reset
);
  localparam int BC_W = $clog2(CFG_BITS);
  localparam int RC_W = $clog2(RESET_PULSE_CYC + 1);

  eng_state_t state_q;
  logic pend_q;
  logic rst_seq_q;
  logic [CFG_BITS-1:0] shreg_q;
  logic [BC_W-1:0] bitcnt_q;
  logic [RC_W-1:0] rstcnt_q;
  logic rst_end;
  logic start_xfer;

  assign rst_end = (state_q == ST_RESET) && (rstcnt_q == '0);
  // Only a fresh reset request defers the transfer; a running sequence needs it
  assign start_xfer = (state_q == ST_IDLE) && pend_q && link.tick &&
                      !(link.rst_req && !rst_seq_q);
  assign link.busy = (state_q != ST_IDLE) || pend_q || rst_seq_q;
  assign link.rst_done = (state_q == ST_GAP) && link.tick && rst_seq_q;

  // Set beats clear, so a write during the load is not lost
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_q <= 1'b0;
    end else if (link.cfg_write || rst_end) begin
      pend_q <= 1'b1;
    end else if (start_xfer) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      rst_seq_q <= 1'b0;
      rstcnt_q <= '0;
      o_conv_reset <= 1'b0;
      o_cs_n <= 1'b1;
      o_sclk <= 1'b0;
      o_sdo <= 1'b0;
      shreg_q <= '0;
      bitcnt_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (link.rst_req && !rst_seq_q) begin
            state_q <= ST_RESET;
            rst_seq_q <= 1'b1;
            o_conv_reset <= 1'b1;
            rstcnt_q <= RC_W'(RESET_PULSE_CYC - 1);
          end else if (start_xfer) begin
            // Latest content is taken only at load time
            state_q <= ST_SHIFT;
            shreg_q <= link.setup[CFG_BITS-1:0];
            o_sdo <= link.setup[CFG_BITS-1];
            bitcnt_q <= BC_W'(CFG_BITS - 1);
            o_cs_n <= 1'b0;
            o_sclk <= 1'b0;
          end
        end
        ST_RESET: begin
          if (rst_end) begin
            state_q <= ST_IDLE;
            o_conv_reset <= 1'b0;
          end else begin
            rstcnt_q <= rstcnt_q - 1'b1;
          end
        end
        ST_SHIFT: begin
          if (link.tick) begin
            if (!o_sclk) begin
              o_sclk <= 1'b1;
            end else begin
              o_sclk <= 1'b0;
              if (bitcnt_q == '0) begin
                state_q <= ST_GAP;
                o_cs_n <= 1'b1;
              end else begin
                shreg_q <= {shreg_q[CFG_BITS-2:0], 1'b0};
                o_sdo <= shreg_q[CFG_BITS-2];
                bitcnt_q <= bitcnt_q - 1'b1;
              end
            end
          end
        end
        ST_GAP: begin
          if (link.tick) begin
            state_q <= ST_IDLE;
            if (!pend_q) begin
              rst_seq_q <= 1'b0;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  a_reset_pulse_len: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_conv_reset) |-> o_conv_reset[*6] ##1 !o_conv_reset)
    else $error("converter reset pulse width wrong");
  a_reconfig_after_reset: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(o_conv_reset) |-> ##[1:20] !o_cs_n)
    else $error("no setup transfer after converter reset");
  a_resend_pending: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (link.cfg_write && state_q == ST_SHIFT) |=> pend_q && link.busy)
    else $error("rewrite during transfer not kept pending");
endmodule : conv_cfg_engine

// ===== conv_adc_model.sv
/*
  Behavioural model of one converter chip on its serial setup link.
  Assumes registered link pins from the block, sampled on the system clock.
*/
`timescale 1ns/1ps
module conv_adc_model (
  // System
  input wire logic i_clk,
  // Link pins
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdo,
  input wire logic i_reset,
  // Observed results
  output logic [27:0] o_word,
  output int o_frames,
  output int o_bits,
  output int o_resets,
  output int o_rst_len
);
  logic sclk_q;
  logic cs_q;
  logic rst_q;
  logic [27:0] sh;
  int nb;
  int rl;

  // Edges seen one system cycle late; sdo holds across the sclk high phase
  always @(posedge i_clk) begin
    sclk_q <= i_sclk;
    cs_q <= i_cs_n;
    rst_q <= i_reset;
    if (i_sclk && !sclk_q && !i_cs_n) begin
      sh <= {sh[26:0], i_sdo};
      nb <= nb + 1;
    end
    if (i_cs_n && !cs_q) begin
      o_word <= sh;
      o_bits <= nb;
      o_frames <= o_frames + 1;
      nb <= 0;
    end
    if (i_reset) begin
      rl <= rl + 1;
    end
    if (!i_reset && rst_q) begin
      o_rst_len <= rl;
      o_resets <= o_resets + 1;
      rl <= 0;
    end
  end
endmodule : conv_adc_model

// ===== tb_top.sv
/*
  Self-checking bench for the converter setup and activity block.
  Assumes a classic Wishbone master and one converter model per link.
*/
`timescale 1ns/1ps
module tb_top;
  import conv_ctrl_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [3:0] sel = '0;
  logic [DAT_W-1:0] wdat = '0;
  logic [DAT_W-1:0] rdat;
  logic ack;
  logic [NUM_CONV-1:0] acq = '0;
  logic [NUM_CONV-1:0] diff;
  logic [NUM_CONV-1:0] sclk;
  logic [NUM_CONV-1:0] cs_n;
  logic [NUM_CONV-1:0] sdo;
  logic [NUM_CONV-1:0] crst;
  logic [NUM_CONV-1:0][CHAN_MAX-1:0] chan_en;
  logic [27:0] word [NUM_CONV];
  int frames [NUM_CONV];
  int bits [NUM_CONV];
  int resets [NUM_CONV];
  int rlen [NUM_CONV];
  logic [DAT_W-1:0] setup_v [NUM_CONV];
  int num_errors = 0;
  int checked = 0;
  localparam logic [ADR_W-1:0] SETUP_OFS [NUM_CONV] = '{OFS_SETUP0, OFS_SETUP1,
                                                      OFS_SETUP2, OFS_SETUP3};

  initial begin
    forever #5 clk = ~clk;
  end

  conv_ctrl_top dut_u (.i_ref_clk(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_acq_active(acq), .o_differential_topology(diff),
    .o_chan_enable(chan_en), .o_cfg_sclk(sclk), .o_cfg_cs_n(cs_n), .o_cfg_sdo(sdo),
    .o_conv_reset(crst));

  for (genvar g = 0; g < NUM_CONV; g++) begin : g_adc
    conv_adc_model adc_u (.i_clk(clk), .i_sclk(sclk[g]), .i_cs_n(cs_n[g]), .i_sdo(sdo[g]),
      .i_reset(crst[g]), .o_word(word[g]), .o_frames(frames[g]), .o_bits(bits[g]),
      .o_resets(resets[g]), .o_rst_len(rlen[g]));
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wb_xfer(input logic w, input logic [ADR_W-1:0] a,
                         input logic [DAT_W-1:0] d, input logic [3:0] s,
                         output logic [DAT_W-1:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    @(posedge clk);
    // No limit here: only the watchdog ends a hung wait
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask : wb_xfer

  task automatic wb_read(input logic [ADR_W-1:0] a, output logic [DAT_W-1:0] q);
    wb_xfer(1'b0, a, '0, 4'hF, q);
  endtask : wb_read

  task automatic wb_write(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d,
                          input logic [3:0] s);
    logic [DAT_W-1:0] q;
    wb_xfer(1'b1, a, d, s, q);
  endtask : wb_write

  // Bounded poll; a transfer runs about 300 cycles
  task automatic wait_idle(input int i);
    logic [DAT_W-1:0] q;
    int n;
    n = 0;
    q = '1;
    while (q[i] !== 1'b0 && n < 400) begin
      wb_read(OFS_STATUS, q);
      n++;
    end
    check("flag clears", 32'(q[i]), 32'h0);
  endtask : wait_idle

  task automatic t_reset_values;
    logic [DAT_W-1:0] q;
    wb_read(OFS_STATUS, q);
    check("status reset", q, 32'h0);
    for (int i = 0; i < NUM_CONV; i++) begin
      wb_read(SETUP_OFS[i], q);
      check("setup reset", q, 32'h0FFF_FFFF);
      check("topology reset", 32'(diff[i]), 32'h0);
      check("chan reset", 32'(chan_en[i]), 32'hFF);
    end
    wb_read(8'h40, q);
    check("unmapped read", q, 32'h0);
  endtask : t_reset_values

  // Differential, range 011 on all four channels
  task automatic t_setup_all;
    logic [2:0] cnt;
    logic [DAT_W-1:0] q;
    int f0;
    for (int i = 0; i < NUM_CONV; i++) begin
      cnt = (i == 0) ? 3'h7 : 3'(i);
      setup_v[i] = {4'h0, 1'b0, cnt, 4'(i), 8'hC5, 12'h6DB};
      f0 = frames[i];
      wb_write(SETUP_OFS[i], setup_v[i], 4'hF);
      repeat (2) @(posedge clk);
      wb_read(OFS_STATUS, q);
      check("flag set", q, 32'(1 << i));
      wait_idle(i);
      check("frame count", 32'(frames[i] - f0), 32'h1);
      check("frame word", 32'(word[i]), 32'(setup_v[i][27:0]));
      check("frame bits", 32'(bits[i]), 32'(CFG_BITS));
      wb_read(SETUP_OFS[i], q);
      check("setup readback", q, setup_v[i]);
      check("topology", 32'(diff[i]), 32'h1);
      check("chan enable", 32'(chan_en[i]), 32'((1 << (cnt[1:0] + 1)) - 1));
    end
  endtask : t_setup_all

  // Rewrite of byte 2 only while the first frame is on the wire
  task automatic t_rewrite;
    int f0;
    int n;
    f0 = frames[0];
    n = 0;
    wb_write(OFS_SETUP0, 32'h0300_06DB, 4'hF);
    while (cs_n[0] !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    check("rewrite frame started", 32'(cs_n[0]), 32'h0);
    repeat (40) @(posedge clk);
    wb_write(OFS_SETUP0, 32'h005A_0000, 4'h4);
    setup_v[0] = 32'h035A_06DB;
    wait_idle(0);
    check("rewrite frames", 32'(frames[0] - f0), 32'h2);
    check("rewrite word", 32'(word[0]), 32'(setup_v[0][27:0]));
  endtask : t_rewrite

  task automatic t_conv_reset;
    logic [DAT_W-1:0] q;
    int r0;
    int f0;
    r0 = resets[1];
    f0 = frames[1];
    wb_write(OFS_CTRL, 32'h0002_0000, 4'h4);
    wb_read(OFS_CTRL, q);
    check("reset request", q, 32'h0002_0000);
    wb_read(OFS_STATUS, q);
    check("flag in reset", q, 32'h2);
    wait_idle(1);
    check("reset pulses", 32'(resets[1] - r0), 32'h1);
    check("reset width", 32'(rlen[1]), 32'(RESET_PULSE_CYC));
    check("reconfig frames", 32'(frames[1] - f0), 32'h1);
    check("reconfig word", 32'(word[1]), 32'(setup_v[1][27:0]));
    wb_read(OFS_CTRL, q);
    check("request clears", q, 32'h0);
  endtask : t_conv_reset

  task automatic t_acq_status;
    logic [DAT_W-1:0] q;
    acq <= 4'h4;
    repeat (3) @(posedge clk);
    wb_read(OFS_STATUS, q);
    check("flag acquiring", q, 32'h4);
    acq <= 4'h0;
    repeat (3) @(posedge clk);
    wb_write(OFS_STATUS, 32'hFFFF_FFFF, 4'hF);
    wb_read(OFS_STATUS, q);
    check("status read only", q, 32'h0);
  endtask : t_acq_status

  task automatic print_verdict;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  // Whole run needs a few thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset_values();
    t_setup_all();
    t_rewrite();
    t_conv_reset();
    t_acq_status();
    print_verdict();
  end
endmodule : tb_top
